// ==== rtl/panel_defines.vh ====
// constants shared by the front panel mode and route display logic
// assumes a 250 MHz clock; every time below is turned into cycles here
`ifndef PANEL_DEFINES_VH
`define PANEL_DEFINES_VH

`define CLK_MHZ          250
// slow blink half period of the local-mode lamp, in ms
`define SLOW_HALF_MS     250
// fast blink half period for a refused local request, in ms
`define FAST_HALF_MS     60
`define SLOW_HALF_CYC    (`SLOW_HALF_MS * 1000 * `CLK_MHZ)
`define FAST_HALF_CYC    (`FAST_HALF_MS * 1000 * `CLK_MHZ)
// number of rapid flashes on refusal
`define REFUSE_FLASHES   3
// mode and view codes; system and video are the reset values
`define MODE_SYSTEM      1'b0
`define MODE_LOCAL       1'b1
`define VIEW_VIDEO       1'b0
`define VIEW_AUDIO       1'b1
// register map of the route/control port
`define ADR_ROUTE_V      4'h0
`define ADR_ROUTE_A      4'h1
`define ADR_CTRL         4'h2
`define ADR_STATUS       4'h3
`define ADR_PEND_V       4'h4
`define ADR_PEND_A       4'h5
`define CTRL_LOCK_BIT    0
`define ROUTE_RESET      4'h0

`endif

// ==== rtl/blink_timer.v ====
// blink_timer: free square wave with a programmable half period
// assumes a single clock; restart realigns the phase to lit
`timescale 1ns/1ps

module blink_timer #(
    parameter HALF_CYC = 1000
) (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // control
    input  wire        restart,
    // output
    output reg         wave_r,
    output reg         toggle_r
);

    reg  [31:0] count_r;

    // ===================================================
    // half period counter; toggle_r pulses on each edge of the wave except one made by restart
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_r  <= 32'h0;
            wave_r   <= 1'b0;
            toggle_r <= 1'b0;
        end else if (restart) begin
            count_r  <= 32'h0;
            wave_r   <= 1'b1;
            toggle_r <= 1'b0;
        end else if (count_r == HALF_CYC - 1) begin
            count_r  <= 32'h0;
            wave_r   <= ~wave_r;
            toggle_r <= 1'b1;
        end else begin
            count_r  <= count_r + 32'h1;
            toggle_r <= 1'b0;
        end
    end

endmodule // blink_timer

// ==== rtl/route_display.v ====
// route_display: turns a route table and a pressed button into lamps
// assumes one 2-bit input index per output, NOUT outputs, NIN inputs
`timescale 1ns/1ps

module route_display #(
    parameter NIN  = 4,
    parameter NOUT = 2
) (
    // route of the viewed portion, output k at bits 2k+1:2k
    input  wire [2*NOUT-1:0] route,
    // pressed buttons, one-hot or zero
    input  wire [NIN-1:0]    in_sel,
    input  wire [NOUT-1:0]   out_sel,
    // lamps
    output wire [NIN-1:0]    in_lamp,
    output wire [NOUT-1:0]   out_lamp
);

    reg  [1:0] src;
    integer    k;

    // input feeding the chosen output; lowest pressed output wins
    always @* begin
        src = 2'h0;
        for (k = NOUT - 1; k >= 0; k = k - 1) begin
            if (out_sel[k]) begin
                src = route[2*k +: 2];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NOUT; g = g + 1) begin : g_out
            // lit when fed by the pressed input or shares the source
            assign out_lamp[g] = in_sel[route[2*g +: 2]]
                | ((|out_sel) && route[2*g +: 2] == src);
        end
        for (g = 0; g < NIN; g = g + 1) begin : g_in
            assign in_lamp[g] = (|out_sel) && src == g;
        end
    endgenerate

endmodule // route_display

// ==== rtl/panel_mode_ctrl.v ====
// panel_mode_ctrl: front panel mode and route display of a 4x2 switcher
// assumes buttons are clean one-cycle press pulses synchronous to clock
//
// Notes on behaviour
// - always exactly system mode or local mode
// - system mode: only remote changes routes
// - local mode: panel buttons change routes
// - system button selects system mode
// - local button selects local unless locked
// - system lamp steady in system mode only
// - local lamp blinks during local mode
// - lock refuses local request, stays system
// - refused request: three fast flashes, off
// - in system mode, input press lights outputs it feeds
// - in system mode, output press lights source and siblings
// - split lamp when audio differs from video
// - audio or video view lamp shows portion
// - view buttons choose displayed portion
// - split button ignored in system mode
// - local edits pend until commit press
// - lock in local forces system, remote routes
`timescale 1ns/1ps
`include "panel_defines.vh"

module panel_mode_ctrl #(
    parameter NIN           = 4,
    parameter NOUT          = 2,
    parameter SLOW_HALF_CYC = `SLOW_HALF_CYC,
    parameter FAST_HALF_CYC = `FAST_HALF_CYC
) (
    // clock and reset
    input  wire              clock,
    input  wire              rstn,
    // register port
    input  wire [3:0]        addr,
    input  wire [31:0]       wdata,
    input  wire              wr,
    input  wire              rd,
    output reg  [31:0]       rdata_r,
    // front panel buttons, one-cycle pulses
    input  wire              remote_control_mode_button,
    input  wire              local_mode_button,
    input  wire [NIN-1:0]    input_button,
    input  wire [NOUT-1:0]   output_button,
    input  wire              audio_view_button,
    input  wire              video_view_button,
    input  wire              split_button,
    input  wire              commit_button,
    // front panel lamps
    output wire              system_lamp,
    output wire              local_lamp,
    output wire [NIN-1:0]    input_lamp,
    output wire [NOUT-1:0]   output_lamp,
    output wire              split_lamp,
    output wire              audio_view_lamp,
    output wire              video_view_lamp,
    output wire              commit_lamp,
    // active routes towards the crosspoint
    output reg  [2*NOUT-1:0] route_video_r,
    output reg  [2*NOUT-1:0] route_audio_r
);

    // ===================================================
    // state
    localparam ST_SYSTEM = 2'h0;
    localparam ST_LOCAL  = 2'h1;
    localparam ST_REFUSE = 2'h2;
    // ST_REFUSE still counts as system mode; it only adds flashes

    reg  [1:0]        state_r;
    reg  [1:0]        state_nxt;
    reg               lock_r;
    reg               view_r;
    reg               split_en_r;
    reg  [NIN-1:0]    held_in_r;
    reg  [NOUT-1:0]   held_out_r;
    reg  [2*NOUT-1:0] pend_v_r;
    reg  [2*NOUT-1:0] pend_a_r;
    reg  [1:0]        edit_src_r;
    reg               edit_on_r;
    reg  [2:0]        flash_cnt_r;

    wire        is_local  = (state_r == ST_LOCAL);
    wire        is_system = ~is_local;
    wire        lock_wr   = wr && addr == `ADR_CTRL;
    wire        lock_nxt  = lock_wr ? wdata[`CTRL_LOCK_BIT] : lock_r;
    wire        lock_rise = lock_nxt && !lock_r;
    wire        slow_wave;
    wire        fast_wave;
    wire        fast_tog;
    // edits wait while the pending tables differ from the active ones
    wire        pending   = (pend_v_r != route_video_r)
                          | (pend_a_r != route_audio_r);

    // ===================================================
    // blink sources; the slow wave runs free, so the first local
    // phase may be short, while the fast wave restarts per refusal
    // so that all three flashes come out whole
    blink_timer #(.HALF_CYC(SLOW_HALF_CYC)) u_slow (
        .clock    (clock),
        .rstn     (rstn),
        .restart  (1'b0),
        .wave_r   (slow_wave),
        .toggle_r ()
    );

    blink_timer #(.HALF_CYC(FAST_HALF_CYC)) u_fast (
        .clock    (clock),
        .rstn     (rstn),
        .restart  (state_r != ST_REFUSE && state_nxt == ST_REFUSE),
        .wave_r   (fast_wave),
        .toggle_r (fast_tog)
    );

    // ===================================================
    // mode machine; stays put unless a valid press, the lock or the end of the flashes acts
    // the lock is judged on its next value, so a lock written in the
    // same cycle as a local press already refuses that press
    wire        local_ok   = local_mode_button && !lock_nxt;
    wire        local_deny = local_mode_button && lock_nxt;
    wire        flash_done = fast_tog && !fast_wave
                           && flash_cnt_r == `REFUSE_FLASHES - 1;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_SYSTEM: begin
                if (local_ok) begin
                    state_nxt = ST_LOCAL;
                end else if (local_deny) begin
                    state_nxt = ST_REFUSE;
                end
            end
            ST_LOCAL: begin
                if (lock_rise) begin
                    state_nxt = ST_SYSTEM;
                end else if (remote_control_mode_button) begin
                    state_nxt = ST_SYSTEM;
                end
            end
            ST_REFUSE: begin
                // refused request keeps system mode while flashing
                if (flash_done) begin
                    state_nxt = ST_SYSTEM;
                end else if (local_ok) begin
                    state_nxt = ST_LOCAL;
                end
            end
            default: begin
                state_nxt = ST_SYSTEM;
            end
        endcase
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_r     <= ST_SYSTEM;
            flash_cnt_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            // count falling edges of the fast wave = completed flashes
            if (state_r != ST_REFUSE) begin
                flash_cnt_r <= 3'h0;
            end else if (fast_tog && !fast_wave) begin
                flash_cnt_r <= flash_cnt_r + 3'h1;
            end
        end
    end

    // ===================================================
    // lock flag, written by the remote controller only
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_r <= 1'b0;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    // view selection; audio wins if both keys come together, which a
    // real panel cannot do but keeps the flag defined
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            view_r <= `VIEW_VIDEO;
        end else if (audio_view_button) begin
            view_r <= `VIEW_AUDIO;
        end else if (video_view_button) begin
            view_r <= `VIEW_VIDEO;
        end
    end

    // split key only acts in local mode; leaving local keeps the
    // setting so the next local session starts where it stopped
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            split_en_r <= 1'b0;
        end else if (split_button && is_local) begin
            split_en_r <= ~split_en_r;
        end
    end

    // ===================================================
    // held buttons for the system-mode route view; a new press replaces
    // them, and local mode clears them so stale lamps never linger
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            held_in_r  <= {NIN{1'b0}};
            held_out_r <= {NOUT{1'b0}};
        end else if (is_local) begin
            held_in_r  <= {NIN{1'b0}};
            held_out_r <= {NOUT{1'b0}};
        end else if (|input_button) begin
            held_in_r  <= input_button;
            held_out_r <= {NOUT{1'b0}};
        end else if (|output_button) begin
            held_in_r  <= {NIN{1'b0}};
            held_out_r <= output_button;
        end
    end

    // ===================================================
    // active routes: remote writes in system mode, panel commit in
    // local mode; a remote write during local mode is dropped, not
    // queued, so the remote side must rewrite after taking control
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            route_video_r <= {NOUT{2'h0}};
            route_audio_r <= {NOUT{2'h0}};
        end else if (!is_local) begin
            if (wr && addr == `ADR_ROUTE_V) begin
                route_video_r <= wdata[2*NOUT-1:0];
            end
            if (wr && addr == `ADR_ROUTE_A) begin
                route_audio_r <= wdata[2*NOUT-1:0];
            end
        end else if (commit_button) begin
            route_video_r <= pend_v_r;
            route_audio_r <= pend_a_r;
        end
    end

    // source picked by the last input press in local mode
    integer k;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            edit_src_r <= 2'h0;
            edit_on_r  <= 1'b0;
        end else if (!is_local) begin
            edit_on_r  <= 1'b0;
        end else begin
            for (k = 0; k < NIN; k = k + 1) begin
                if (input_button[k]) begin
                    edit_src_r <= k[1:0];
                    edit_on_r  <= 1'b1;
                end
            end
        end
    end

    // pending tables track the active routes outside local mode, so
    // local editing starts from what is really switched, unless a remote
    // route write lands in the same cycle as the local press
    integer j;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pend_v_r <= {NOUT{2'h0}};
            pend_a_r <= {NOUT{2'h0}};
        end else if (!is_local) begin
            pend_v_r <= route_video_r;
            pend_a_r <= route_audio_r;
        end else begin
            // panel edits go to the pending table first
            for (j = 0; j < NOUT; j = j + 1) begin
                if (output_button[j] && edit_on_r) begin
                    if (!split_en_r || view_r == `VIEW_VIDEO) begin
                        pend_v_r[2*j +: 2] <= edit_src_r;
                    end
                    if (!split_en_r || view_r == `VIEW_AUDIO) begin
                        pend_a_r[2*j +: 2] <= edit_src_r;
                    end
                end
            end
        end
    end

    // ===================================================
    // route view lamps; in local mode the view takes the pending table, but the held buttons stay clear so the lamps stay dark
    wire [2*NOUT-1:0] view_route =
        is_local ? (view_r ? pend_a_r : pend_v_r)
                 : (view_r ? route_audio_r : route_video_r);
    wire [NIN-1:0]    disp_in;
    wire [NOUT-1:0]   disp_out;

    route_display #(.NIN(NIN), .NOUT(NOUT)) u_disp (
        .route    (view_route),
        .in_sel   (held_in_r),
        .out_sel  (held_out_r),
        .in_lamp  (disp_in),
        .out_lamp (disp_out)
    );

    assign input_lamp      = disp_in;
    assign output_lamp     = disp_out;
    // a refused request is still system mode, so the lamp stays lit
    // through the flashes
    assign system_lamp     = is_system;
    assign local_lamp      = is_local ? slow_wave
                           : (state_r == ST_REFUSE && fast_wave);
    assign split_lamp      = route_audio_r != route_video_r;
    assign audio_view_lamp = view_r == `VIEW_AUDIO;
    assign video_view_lamp = view_r == `VIEW_VIDEO;
    // commit lamp flashes fast while edits wait
    assign commit_lamp     = is_local && pending && fast_wave;

    // ===================================================
    // register read mux; unmapped offsets and idle cycles give zero
    reg  [31:0] rdata_nxt;
    always @* begin
        rdata_nxt = 32'h0;
        if (rd) begin
            case (addr)
                `ADR_ROUTE_V: rdata_nxt = {{(32-2*NOUT){1'b0}}, route_video_r};
                `ADR_ROUTE_A: rdata_nxt = {{(32-2*NOUT){1'b0}}, route_audio_r};
                `ADR_CTRL:    rdata_nxt = {31'h0, lock_r};
                `ADR_STATUS:  rdata_nxt = {28'h0, view_r, split_en_r,
                                           pending, is_local};
                `ADR_PEND_V:  rdata_nxt = {{(32-2*NOUT){1'b0}}, pend_v_r};
                `ADR_PEND_A:  rdata_nxt = {{(32-2*NOUT){1'b0}}, pend_a_r};
                default:      rdata_nxt = 32'h0;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

endmodule // panel_mode_ctrl

// ==== verif/panel_mode_ctrl_assertions.sv ====
// checker for panel_mode_ctrl: mode, lamp and route relations
// assumes it is bound to the top module; it mirrors the lock bit
`timescale 1ns/1ps
`include "panel_defines.vh"
// ====================================================
// checker
module panel_mode_ctrl_assertions #(
    parameter NOUT          = 2,
    parameter SLOW_HALF_CYC = 4
) (
    // clock, reset and bus
    input wire logic              clock,
    input wire logic              rstn,
    input wire logic [3:0]        addr,
    input wire logic [31:0]       wdata,
    input wire logic              wr,
    // buttons
    input wire logic              remote_control_mode_button,
    input wire logic              local_mode_button,
    input wire logic [NOUT-1:0]   output_button,
    input wire logic              audio_view_button,
    input wire logic              video_view_button,
    input wire logic              commit_button,
    // lamps and routes
    input wire logic              system_lamp,
    input wire logic              local_lamp,
    input wire logic              split_lamp,
    input wire logic              audio_view_lamp,
    input wire logic              video_view_lamp,
    input wire logic [2*NOUT-1:0] route_video_r,
    input wire logic [2*NOUT-1:0] route_audio_r
);
    logic        lock_r;
    logic        lamp_q_r;
    logic [31:0] still_r;
    // lock mirror and blink phase length; a lamp stuck in local mode
    // shows up as a phase longer than the slow half period
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lock_r   <= 1'b0;
            lamp_q_r <= 1'b0;
            still_r  <= 32'h0;
        end else begin
            if (wr && addr == `ADR_CTRL)
                lock_r <= wdata[0];
            lamp_q_r <= local_lamp;
            if (system_lamp || local_lamp != lamp_q_r)
                still_r <= 32'h0;
            else
                still_r <= still_r + 32'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_SYS_PRESS: assert property (
        remote_control_mode_button |=> system_lamp)
        else $error("system press kept local mode");
    AST_LOCAL_PRESS: assert property (
        local_mode_button && !lock_r && !wr |=> !system_lamp)
        else $error("local press refused while unlocked");
    AST_LOCKED: assert property (
        local_mode_button && lock_r |=> system_lamp [*8])
        else $error("locked panel left system mode");
    AST_SYS_ROUTE: assert property (
        system_lamp && !wr |=>
        $stable(route_video_r) && $stable(route_audio_r))
        else $error("route moved without a remote write");
    AST_PEND: assert property (
        !system_lamp && !commit_button |=> $stable(route_video_r))
        else $error("local route moved without commit");
    AST_BLINK: assert property (
        still_r < SLOW_HALF_CYC + 2)
        else $error("local lamp stopped blinking");
    AST_SPLIT: assert property (
        system_lamp |-> split_lamp == (route_video_r != route_audio_r))
        else $error("split lamp wrong");
    AST_VIEW_ONE: assert property (
        audio_view_lamp != video_view_lamp)
        else $error("view lamps not exclusive");
    AST_VIEW_SEL: assert property (
        audio_view_button && !video_view_button |=> audio_view_lamp)
        else $error("audio view not taken");
    AST_LOCK_SYS: assert property (
        wr && addr == `ADR_CTRL && wdata[0] |=> system_lamp)
        else $error("lock did not force system mode");
endmodule // panel_mode_ctrl_assertions

bind panel_mode_ctrl panel_mode_ctrl_assertions #(
    .NOUT(NOUT), .SLOW_HALF_CYC(SLOW_HALF_CYC)) chk_i (.*);

// ==== verif/remote_ctrl_model.sv ====
// remote controller model: drives the register port of the panel
// assumes one clock; strobes are one cycle, set right after an edge
`timescale 1ns/1ps
// ====================================================
// model
module remote_ctrl_model (
    // clock
    input  wire logic        clock,
    // register port
    output logic      [3:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [31:0] rdata_r
);
    // idle bus at time zero
    initial begin
        addr  = 4'h0;
        wdata = 32'h0;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // one write cycle; returns once the edge has taken it
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        d = rdata_r;
    endtask
endmodule // remote_ctrl_model

// ==== verif/panel_mode_ctrl_tb.sv ====
// testbench of panel_mode_ctrl with short blink periods
// assumes the remote model drives the register port
`timescale 1ns/1ps
`include "panel_defines.vh"
// ====================================================
// bench
module panel_mode_ctrl_tb;
    logic        clock = 1'b0;
    logic        rstn  = 1'b0;
    logic [11:0] btn   = 12'h000;
    logic [31:0] d;
    int          n;
    logic        ok;
    logic        prev;
    int          bad_count = 0;
    int          n_checks  = 0;
    wire  [3:0]  addr;
    wire  [31:0] wdata;
    wire         wr, rd;
    wire  [31:0] rdata_r;
    wire  [3:0]  input_lamp, rv, ra;
    wire  [1:0]  output_lamp;
    wire         system_lamp, local_lamp, split_lamp, commit_lamp;
    wire         audio_view_lamp, video_view_lamp;
    always #2 clock = ~clock;
    // button bits: sys, local, in[3:0], out[1:0], a, v, split, commit
    panel_mode_ctrl #(.SLOW_HALF_CYC(4), .FAST_HALF_CYC(2))
        panel_mode_ctrl_i (
        .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata_r(rdata_r),
        .remote_control_mode_button(btn[0]),
        .local_mode_button(btn[1]), .input_button(btn[5:2]),
        .output_button(btn[7:6]), .audio_view_button(btn[8]),
        .video_view_button(btn[9]), .split_button(btn[10]),
        .commit_button(btn[11]), .system_lamp(system_lamp),
        .local_lamp(local_lamp), .input_lamp(input_lamp),
        .output_lamp(output_lamp), .split_lamp(split_lamp),
        .audio_view_lamp(audio_view_lamp),
        .video_view_lamp(video_view_lamp), .commit_lamp(commit_lamp),
        .route_video_r(rv), .route_audio_r(ra));
    remote_ctrl_model remote_ctrl_model_i (.clock(clock),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one-cycle press, returns after the edge that takes it
    task automatic press(input logic [11:0] v);
        @(posedge clock);
        btn <= v;
        @(posedge clock);
        btn <= 12'h000;
        #1;
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_reset;
        chk({system_lamp, local_lamp, video_view_lamp}, 3'b101);
        chk({ra, rv}, 8'h00);
        remote_ctrl_model_i.rd_reg(`ADR_STATUS, d);
        chk(d, 32'h0);
        remote_ctrl_model_i.rd_reg(4'hf, d);
        chk(d, 32'h0);
    endtask
    task automatic t_system;
        remote_ctrl_model_i.wr_reg(`ADR_ROUTE_V, 32'h4);
        remote_ctrl_model_i.wr_reg(`ADR_ROUTE_A, 32'h4);
        press(12'h040);
        press(12'h800);
        chk({ra, rv}, 8'h44);
        press(12'h008);
        chk(output_lamp, 2'b10);
        press(12'h080);
        chk({input_lamp, output_lamp}, 6'b0010_10);
        chk(split_lamp, 1'b0);
        remote_ctrl_model_i.wr_reg(`ADR_ROUTE_A, 32'h6);
        chk(split_lamp, 1'b1);
        remote_ctrl_model_i.rd_reg(`ADR_ROUTE_A, d);
        chk(d, 32'h6);
        press(12'h100);
        chk({audio_view_lamp, video_view_lamp}, 2'b10);
        press(12'h010);
        chk(output_lamp, 2'b01);
        press(12'h400);
        remote_ctrl_model_i.rd_reg(`ADR_STATUS, d);
        chk(d & 32'h4, 32'h0);
        press(12'h200);
        chk({audio_view_lamp, video_view_lamp}, 2'b01);
    endtask
    task automatic t_local;
        press(12'h002);
        chk(system_lamp, 1'b0);
        n = 0;
        prev = local_lamp;
        repeat (20) begin
            @(posedge clock);
            #1;
            if (local_lamp !== prev) n++;
            prev = local_lamp;
        end
        chk({31'h0, n > 1}, 32'h1);
        remote_ctrl_model_i.rd_reg(`ADR_STATUS, d);
        chk(d & 32'h1, 32'h1);
        remote_ctrl_model_i.wr_reg(`ADR_ROUTE_V, 32'h0);
        chk(rv, 4'h4);
        press(12'h020);
        press(12'h040);
        chk({ra, rv}, 8'h64);
        remote_ctrl_model_i.rd_reg(`ADR_PEND_V, d);
        chk(d, 32'h7);
        ok = 1'b0;
        repeat (8) begin
            @(posedge clock);
            #1;
            if (commit_lamp === 1'b1) ok = 1'b1;
        end
        chk(ok, 1'b1);
        press(12'h800);
        chk({ra, rv}, 8'h77);
        chk(commit_lamp, 1'b0);
        press(12'h001);
        chk(system_lamp, 1'b1);
    endtask
    task automatic t_lock;
        press(12'h002);
        remote_ctrl_model_i.wr_reg(`ADR_CTRL, 32'h1);
        chk({system_lamp, ra, rv}, 9'h177);
        prev = local_lamp;
        ok = 1'b1;
        n = 0;
        press(12'h002);
        repeat (40) begin
            if (local_lamp && !prev) n++;
            if (system_lamp !== 1'b1) ok = 1'b0;
            prev = local_lamp;
            @(posedge clock);
            #1;
        end
        chk(n, 3);
        chk(ok, 1'b1);
        chk(local_lamp, 1'b0);
        remote_ctrl_model_i.wr_reg(`ADR_CTRL, 32'h0);
    endtask
    // guard against a hung run
    initial begin
        #200000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        t_reset;
        t_system;
        t_local;
        t_lock;
        print_verdict;
    end
endmodule // panel_mode_ctrl_tb
